// [verilog/wetting_defines.vh]
// constants for the wetting current configuration register block
//
// Summary of operation
// - sink disable bit has no effect: inputs 12-23 are fixed source type
// - source inputs set to 10 or 15 mA scale to 2 mA once closed in continuous mode, unless disabled or in pulse mode
// - level codes: 0,1,2,5,10 mA, else 15
// - pulse time is (code+1) times 64 us
// - bit 3 sets pulse level, inputs 18-23
// - bit 2 sets pulse level, inputs 12-17
// - bit 1 sets pulse level, inputs 6-11
// - bit 0 sets pulse level, inputs 0-5
// - upper level register resets to zero
// - pulse config register resets to zero
// - direction bit 0 source, 1 sink
// - pulse current only where input enabled
`ifndef WETTING_DEFINES_VH
`define WETTING_DEFINES_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define IDX_DIRECTION 6'h1c
`define IDX_UPPER_LEVEL 6'h1e
`define IDX_PULSE_CONFIG 6'h1f
`define IDX_PULSE_ENABLES 6'h20
`define IDX_CONTROL 6'h30
`define IDX_STATUS 6'h31

// ****************************************************************
// reset values and writable bit masks
// ****************************************************************
`define RST_DIRECTION 24'h000000
`define RST_UPPER_LEVEL 24'h000000
`define RST_PULSE_CONFIG 24'h000000
`define RST_PULSE_ENABLES 24'h000000
`define RST_CONTROL 24'h000000
`define MASK_DIRECTION 24'h0003ff
`define MASK_UPPER_LEVEL 24'h7fffff
`define MASK_PULSE_CONFIG 24'h00007f
`define MASK_PULSE_ENABLES 24'hffffff
`define MASK_CONTROL 24'h000003

// ****************************************************************
// field positions
// ****************************************************************
`define POS_SINK_SCALE_DIS 22
`define POS_SOURCE_SCALE_DIS 21
`define LEVEL_FIELD_WIDTH 3
`define POS_PULSE_DURATION 4
`define POS_PULSE_GROUP0 0
`define CONFIGURABLE_INPUTS 10
`define PULSE_GROUP_SIZE 6
`define POS_CTRL_CONTINUOUS 0
`define POS_CTRL_PULSE_MODE 1
`define POS_CTRL_PULSE_START 2

// ****************************************************************
// currents in mA and timing
// ****************************************************************
`define MA_SCALED 4'h2
`define MA_PULSE_LOW 4'ha
`define MA_PULSE_HIGH 4'hf
`define PULSE_UNIT_US 64
`define CLOCK_MHZ 100

`endif

// [verilog/level_decoder.v]
// level code decoder with continuous-mode auto-scaling for one input
`timescale 1ns/1ps
module level_decoder (
  input wire [2:0] level_code, // 3-bit wetting level field
  input wire continuous_mode, // device in continuous mode
  input wire scale_disable, // scaling disable bit for this input's type
  input wire switch_closed, // switch on this input is closed
  output wire [3:0] current_ma // resulting current in mA
);
`include "wetting_defines.vh"

  // ****************************************************************
  // decode
  // ****************************************************************
  function [3:0] decode_ma;
    input [2:0] code;
    begin
      case (code)
        3'h0: decode_ma = 4'h0;
        3'h1: decode_ma = 4'h1;
        3'h2: decode_ma = 4'h2;
        3'h3: decode_ma = 4'h5;
        3'h4: decode_ma = 4'ha;
        default: decode_ma = 4'hf; // codes 5 to 7 share the top level
      endcase
    end
  endfunction

  wire [3:0] nominal_ma;
  wire high_setting;

  // only the 10 and 15 mA settings are lowered, and only once closed
  assign nominal_ma = decode_ma(level_code);
  assign high_setting = (level_code >= 3'h4);
  assign current_ma = (continuous_mode && high_setting && switch_closed && !scale_disable) ?
    `MA_SCALED : nominal_ma;

endmodule // level_decoder

// [verilog/pulse_timer.v]
// cleaning-pulse activation timer
`timescale 1ns/1ps
module pulse_timer #(
  parameter UNIT_CYCLES = 6400 // cycles per 64 us step
) (
  input wire clock, // system clock
  input wire srst, // synchronous reset, active high
  input wire start, // one-cycle pulse launching a cleaning pulse
  input wire abort, // level, ends the pulse early
  input wire [2:0] duration, // duration code
  output reg active // high while the pulse runs
);

  reg [15:0] count_reg;
  wire [31:0] total;

  // length is (code + 1) steps; a restart while running reloads
  assign total = ({29'h0, duration} + 32'h1) * UNIT_CYCLES;

  // ****************************************************************
  // count down
  // ****************************************************************
  always @(posedge clock) begin
    if (srst) begin
      active <= 1'b0;
      count_reg <= 16'h0000;
    end else if (abort) begin
      active <= 1'b0;
      count_reg <= 16'h0000;
    end else if (start) begin
      active <= 1'b1;
      count_reg <= total[15:0] - 16'h0001;
    end else if (active) begin
      if (count_reg == 16'h0000) begin
        active <= 1'b0;
      end else begin
        count_reg <= count_reg - 16'h0001;
      end
    end
  end

endmodule // pulse_timer

// [verilog/wetting_current_config_regs.v]
// wetting current configuration registers with wishbone slave
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`include "wetting_defines.vh"
module wetting_current_config_regs #(
  parameter ADDR_WIDTH = 8, // byte address width
  parameter PULSE_UNIT_CYCLES = `PULSE_UNIT_US * `CLOCK_MHZ // cycles per 64 us
) (
  input wire clock, // system clock, 100 MHz
  input wire srst, // synchronous reset, active high
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  input wire wb_we_i, // wishbone write enable
  input wire [ADDR_WIDTH-1:0] wb_adr_i, // wishbone byte address
  input wire [3:0] wb_sel_i, // wishbone byte selects
  input wire [31:0] wb_dat_i, // wishbone write data
  output reg [31:0] wb_dat_o, // wishbone read data
  output reg wb_ack_o, // wishbone acknowledge
  input wire [23:0] switch_closed, // per-input switch closure
  output reg [47:0] level_current_ma, // inputs 12..23, 4 bits each
  output reg [95:0] pulse_current_ma, // inputs 0..23, 4 bits each
  output reg pulse_active // cleaning pulse running
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // byte-lane merge restricted to the writable bits of a register
  function [23:0] merge_write;
    input [23:0] old_value;
    input [31:0] wdata;
    input [3:0] sel;
    input [23:0] mask;
    reg [23:0] lanes;
    begin
      lanes = {{8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      merge_write = ((old_value & ~(lanes & mask)) | (wdata[23:0] & lanes & mask)) & mask;
    end
  endfunction

  // which 3-bit field of the upper level register feeds input n
  function [2:0] level_field_index;
    input integer n;
    begin
      if (n == 23) begin
        level_field_index = 3'd6;
      end else if (n == 22) begin
        level_field_index = 3'd5;
      end else begin
        level_field_index = n[3:1] - 3'd6; // pairs from 12/13 upward
      end
    end
  endfunction

  // ****************************************************************
  // register storage
  // ****************************************************************
  reg [23:0] direction_reg;
  reg [23:0] upper_wetting_level_select_reg;
  reg [23:0] cleaning_pulse_config_reg;
  reg [23:0] cleaning_pulse_input_enables_reg;
  reg [23:0] control_reg;
  reg pulse_start_reg;
  reg [31:0] read_next;
  wire [5:0] word_index;
  wire request;
  wire commit;
  wire timer_active;

  assign word_index = wb_adr_i[7:2];
  // a new request is one not yet acknowledged
  assign request = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land on the edge where the master sees ack
  assign commit = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;

  // ****************************************************************
  // wishbone answer: ack one cycle after the request is seen
  // ****************************************************************
  always @(posedge clock) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= request;
      if (request && !wb_we_i) begin
        wb_dat_o <= read_next;
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // read mux; unmapped words read zero and still get an ack
  always @* begin
    read_next = 32'h00000000;
    if (word_index == `IDX_DIRECTION) begin
      read_next = {8'h00, direction_reg & `MASK_DIRECTION};
    end else if (word_index == `IDX_UPPER_LEVEL) begin
      read_next = {8'h00, upper_wetting_level_select_reg & `MASK_UPPER_LEVEL};
    end else if (word_index == `IDX_PULSE_CONFIG) begin
      read_next = {8'h00, cleaning_pulse_config_reg & `MASK_PULSE_CONFIG};
    end else if (word_index == `IDX_PULSE_ENABLES) begin
      read_next = {8'h00, cleaning_pulse_input_enables_reg};
    end else if (word_index == `IDX_CONTROL) begin
      read_next = {8'h00, control_reg & `MASK_CONTROL};
    end else if (word_index == `IDX_STATUS) begin
      read_next = {31'h00000000, timer_active};
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************

  // the upper byte lane and the bits above 23 are never stored
  always @(posedge clock) begin
    if (srst) begin
      direction_reg <= `RST_DIRECTION;
      upper_wetting_level_select_reg <= `RST_UPPER_LEVEL;
      cleaning_pulse_config_reg <= `RST_PULSE_CONFIG;
      cleaning_pulse_input_enables_reg <= `RST_PULSE_ENABLES;
      control_reg <= `RST_CONTROL;
    end else if (commit) begin
      if (word_index == `IDX_DIRECTION) begin
        direction_reg <= merge_write(direction_reg, wb_dat_i, wb_sel_i, `MASK_DIRECTION);
      end else if (word_index == `IDX_UPPER_LEVEL) begin
        upper_wetting_level_select_reg <= merge_write(upper_wetting_level_select_reg,
          wb_dat_i, wb_sel_i, `MASK_UPPER_LEVEL);
      end else if (word_index == `IDX_PULSE_CONFIG) begin
        cleaning_pulse_config_reg <= merge_write(cleaning_pulse_config_reg,
          wb_dat_i, wb_sel_i, `MASK_PULSE_CONFIG);
      end else if (word_index == `IDX_PULSE_ENABLES) begin
        cleaning_pulse_input_enables_reg <= merge_write(cleaning_pulse_input_enables_reg,
          wb_dat_i, wb_sel_i, `MASK_PULSE_ENABLES);
      end else if (word_index == `IDX_CONTROL) begin
        control_reg <= merge_write(control_reg, wb_dat_i, wb_sel_i, `MASK_CONTROL);
      end
    end
  end

  // start is write-only: a one-cycle pulse when bit 2 is written as 1
  always @(posedge clock) begin
    if (srst) begin
      pulse_start_reg <= 1'b0;
    end else begin
      pulse_start_reg <= commit && (word_index == `IDX_CONTROL) && wb_sel_i[0] &&
        wb_dat_i[`POS_CTRL_PULSE_START];
    end
  end

  // ****************************************************************
  // mode decode
  // ****************************************************************
  wire continuous_mode;
  wire cleaning_pulse_mode;
  wire sink_scaling_disable;
  wire source_scaling_disable;
  wire [2:0] cleaning_pulse_duration;
  wire [3:0] pulse_group_level;
  wire [23:0] sink_type_input;

  assign continuous_mode = control_reg[`POS_CTRL_CONTINUOUS];
  // pulse mode has priority: continuous scaling is off while it is set
  assign cleaning_pulse_mode = control_reg[`POS_CTRL_PULSE_MODE];
  assign sink_scaling_disable = upper_wetting_level_select_reg[`POS_SINK_SCALE_DIS];
  assign source_scaling_disable = upper_wetting_level_select_reg[`POS_SOURCE_SCALE_DIS];
  assign cleaning_pulse_duration = cleaning_pulse_config_reg[`POS_PULSE_DURATION+2:
    `POS_PULSE_DURATION];
  assign pulse_group_level = cleaning_pulse_config_reg[`POS_PULSE_GROUP0+3:`POS_PULSE_GROUP0];

  // only the low inputs are selectable; the rest are fixed source type
  assign sink_type_input = {14'h0000, direction_reg[`CONFIGURABLE_INPUTS-1:0]};

  // ****************************************************************
  // cleaning-pulse timer
  // ****************************************************************

  // leaving pulse mode stops a running pulse at once
  pulse_timer #(
    .UNIT_CYCLES(PULSE_UNIT_CYCLES)
  ) u_pulse_timer (
    .clock(clock),
    .srst(srst),
    .start(pulse_start_reg && cleaning_pulse_mode),
    .abort(!cleaning_pulse_mode),
    .duration(cleaning_pulse_duration),
    .active(timer_active)
  );

  // ****************************************************************
  // per-input continuous currents, inputs 12 to 23
  // ****************************************************************
  wire [47:0] level_current_next;
  genvar gi;

  generate
    for (gi = 12; gi < 24; gi = gi + 1) begin : g_level
      wire [2:0] field_sel;
      wire [2:0] code;
      wire scale_dis;

      assign field_sel = level_field_index(gi);
      assign code = upper_wetting_level_select_reg[field_sel*3 +: `LEVEL_FIELD_WIDTH];
      // the disable bit is chosen by this input's current direction
      assign scale_dis = sink_type_input[gi] ? sink_scaling_disable :
        source_scaling_disable;

      level_decoder u_level_decoder (
        .level_code(code),
        .continuous_mode(continuous_mode && !cleaning_pulse_mode),
        .scale_disable(scale_dis),
        .switch_closed(switch_closed[gi]),
        .current_ma(level_current_next[(gi-12)*4 +: 4])
      );
    end
  endgenerate

  // ****************************************************************
  // per-input cleaning-pulse currents, inputs 0 to 23
  // ****************************************************************
  wire [95:0] pulse_current_next;

  generate
    for (gi = 0; gi < 24; gi = gi + 1) begin : g_pulse
      wire group_high;
      wire driven;

      // six inputs per group: bit 0 for 0-5 up to bit 3 for 18-23
      assign group_high = pulse_group_level[gi / `PULSE_GROUP_SIZE];
      assign driven = timer_active && cleaning_pulse_input_enables_reg[gi];
      assign pulse_current_next[gi*4 +: 4] = !driven ? 4'h0 :
        (group_high ? `MA_PULSE_HIGH : `MA_PULSE_LOW);
    end
  endgenerate

  // ****************************************************************
  // registered outputs
  // ****************************************************************

  // one register stage keeps the analog controls glitch free
  always @(posedge clock) begin
    if (srst) begin
      level_current_ma <= 48'h000000000000;
      pulse_current_ma <= 96'h000000000000000000000000;
      pulse_active <= 1'b0;
    end else begin
      level_current_ma <= level_current_next;
      pulse_current_ma <= pulse_current_next;
      pulse_active <= timer_active;
    end
  end

endmodule // wetting_current_config_regs

// [tb/wetting_regs_props.sv]
// assertion checker for the wetting current register block
`timescale 1ns/1ps
module wetting_regs_props #(
  parameter ADDR_WIDTH = 8, // byte address width
  parameter PULSE_UNIT_CYCLES = 4 // cycles per pulse step
) (
  input wire clock, // system clock
  input wire srst, // synchronous reset
  input wire wb_cyc_i, // cycle
  input wire wb_stb_i, // strobe
  input wire wb_we_i, // write enable
  input wire [ADDR_WIDTH-1:0] wb_adr_i, // address
  input wire [3:0] wb_sel_i, // byte selects
  input wire [31:0] wb_dat_i, // write data
  input wire [31:0] wb_dat_o, // read data
  input wire wb_ack_o, // acknowledge
  input wire [23:0] switch_closed, // closures
  input wire [47:0] level_current_ma, // level currents
  input wire [95:0] pulse_current_ma, // pulse currents
  input wire pulse_active // pulse running
);
  // ****************************************************************
  // legal current values, checked nibble by nibble
  // ****************************************************************
  logic lvl_ok;
  logic pls_ok;
  always_comb begin
    lvl_ok = 1'b1;
    pls_ok = 1'b1;
    for (int k = 0; k < 12; k++) begin
      if (!(level_current_ma[k*4+:4] inside {4'h0, 4'h1, 4'h2, 4'h5, 4'ha, 4'hf}))
        lvl_ok = 1'b0;
    end
    for (int k = 0; k < 24; k++) begin
      if (!(pulse_current_ma[k*4+:4] inside {4'h0, 4'ha, 4'hf}))
        pls_ok = 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_no_spurious_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_top_bits_zero: assert property (wb_ack_o |-> wb_dat_o[31:24] == 8'h0)
    else $error("top read bits set");
  a_level_codes: assert property (lvl_ok) else $error("bad level current");
  a_pulse_levels: assert property (pls_ok) else $error("bad pulse current");
  a_no_pulse_idle: assert property (!pulse_active |-> pulse_current_ma == 96'h0)
    else $error("pulse current while idle");
  a_reset_clears: assert property ($fell(srst) |-> level_current_ma == 48'h0 && !pulse_active)
    else $error("outputs not cleared by reset");

  c_pulse: cover property ($rose(pulse_active));
  c_write: cover property (wb_ack_o && wb_we_i);
  c_scaled: cover property (level_current_ma[3:0] == 4'h2);
endmodule // wetting_regs_props

bind wetting_current_config_regs wetting_regs_props #(.ADDR_WIDTH(ADDR_WIDTH),
  .PULSE_UNIT_CYCLES(PULSE_UNIT_CYCLES)) u_props (.clock(clock), .srst(srst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .switch_closed(switch_closed), .level_current_ma(level_current_ma),
  .pulse_current_ma(pulse_current_ma), .pulse_active(pulse_active));

// [tb/wb_host.sv]
// host model: classic wishbone master issuing register cycles
`timescale 1ns/1ps
module wb_host (
  input wire clock, // system clock
  input wire ack, // slave acknowledge
  input wire [31:0] rdata, // slave read data
  output logic cyc = 1'b0, // cycle
  output logic stb = 1'b0, // strobe
  output logic we = 1'b0, // write enable
  output logic [7:0] adr = 8'h0, // byte address
  output logic [3:0] sel = 4'h0, // byte selects
  output logic [31:0] wdata = 32'h0 // write data
);
  logic timed_out = 1'b0;
  // one cycle; idle address and write data show inverted values so stale data is never trusted
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int i;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdata <= d;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (ack !== 1'b1 && i < 50);
    timed_out = (ack !== 1'b1);
    q = rdata;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    adr <= ~a;
    wdata <= ~d;
  endtask
endmodule // wb_host

// [tb/tb_wetting_current_config_regs.sv]
// self-checking bench for the wetting current register block
`timescale 1ns/1ps
module tb_wetting_current_config_regs;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [23:0] switch_closed = 24'h0;
  wire cyc, stb, we, ack, pulse_on;
  wire [7:0] adr;
  wire [3:0] sel;
  wire [31:0] wdata, rdata;
  wire [47:0] level_ma;
  wire [95:0] pulse_ma;
  int num_errors = 0;
  int n_compared = 0;
  logic [31:0] rd_val;

  initial begin
    forever #5 clock = ~clock;
  end

  wb_host host (.clock(clock), .ack(ack), .rdata(rdata), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .wdata(wdata));
  // short pulse step keeps the run brief
  wetting_current_config_regs #(.PULSE_UNIT_CYCLES(4)) dut (.clock(clock), .srst(srst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdata), .wb_dat_o(rdata), .wb_ack_o(ack), .switch_closed(switch_closed),
    .level_current_ma(level_ma), .pulse_current_ma(pulse_ma), .pulse_active(pulse_on));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    host.xfer(w, a, d, rd_val);
    if (host.timed_out) begin
      num_errors++;
      final_report();
    end
  endtask
  // write, then let the registered outputs follow
  task automatic wr_settle(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (2) @(posedge clock);
  endtask
  function automatic logic [3:0] ma(input logic [2:0] c);
    case (c)
      3'h0: ma = 4'h0;
      3'h1: ma = 4'h1;
      3'h2: ma = 4'h2;
      3'h3: ma = 4'h5;
      3'h4: ma = 4'ha;
      default: ma = 4'hf;
    endcase
  endfunction

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_reset();
    bus(1'b0, 8'h78, 32'h0);
    check(rd_val, 32'h0);
    bus(1'b0, 8'h7c, 32'h0);
    check(rd_val, 32'h0);
    check(pulse_ma, 96'h0);
    check(pulse_on, 1'b0);
    check(level_ma, 48'h0);
    $display("test_reset done");
  endtask
  task automatic test_masks();
    bus(1'b1, 8'h78, 32'hffffffff);
    bus(1'b0, 8'h78, 32'h0);
    check(rd_val, 32'h007fffff);
    bus(1'b1, 8'h7c, 32'hffffffff);
    bus(1'b0, 8'h7c, 32'h0);
    check(rd_val, 32'h0000007f);
    bus(1'b0, 8'hfc, 32'h0);
    check(rd_val, 32'h0);
    $display("test_masks done");
  endtask
  task automatic test_decode();
    logic [2:0] c;
    bus(1'b1, 8'hc0, 32'h0);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wr_settle(8'h78, {11'h0, {7{c}}});
      check(level_ma, {12{ma(c)}});
    end
    $display("test_decode done");
  endtask
  // inputs 12..23 are fixed source type, so the sink disable must not matter
  task automatic test_scale();
    bus(1'b1, 8'hc0, 32'h1);
    switch_closed <= 24'hfff000;
    wr_settle(8'h78, {11'h0, {7{3'h4}}});
    check(level_ma, {12{4'h2}});
    wr_settle(8'h78, {9'h0, 2'h2, {7{3'h5}}});
    check(level_ma, {12{4'h2}});
    wr_settle(8'h78, {9'h0, 2'h1, {7{3'h4}}});
    check(level_ma, {12{4'ha}});
    // pulse mode is not continuous mode, so no lowering while it is set
    wr_settle(8'h78, {11'h0, {7{3'h4}}});
    wr_settle(8'hc0, 32'h3);
    check(level_ma, {12{4'ha}});
    wr_settle(8'hc0, 32'h1);
    switch_closed <= 24'h0;
    wr_settle(8'h78, {11'h0, {7{3'h5}}});
    check(level_ma, {12{4'hf}});
    $display("test_scale done");
  endtask
  task automatic test_pulse();
    logic [95:0] exp;
    int n;
    for (int k = 0; k < 24; k++)
      exp[k*4+:4] = (k == 0) ? 4'h0 : (((k / 6) % 2 == 0) ? 4'hf : 4'ha);
    bus(1'b1, 8'h80, 32'h00fffffe);
    bus(1'b1, 8'h7c, 32'h00000015);
    bus(1'b1, 8'hc0, 32'h2);
    bus(1'b1, 8'hc0, 32'h6);
    n = 0;
    while (pulse_on !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (pulse_on !== 1'b1) begin
      num_errors++;
      final_report();
    end
    n = 0;
    while (pulse_on === 1'b1 && n < 100) begin
      if (n == 1)
        check(pulse_ma, exp);
      @(posedge clock);
      n++;
    end
    check(n, 8);
    check(pulse_ma, 96'h0);
    $display("test_pulse done");
  endtask

  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    test_reset();
    test_masks();
    test_decode();
    test_scale();
    test_pulse();
    // reset in mid-run must clear what the scenarios left behind
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    test_reset();
    final_report();
  end
endmodule // tb_wetting_current_config_regs
